// File: verilog/ibs_pkg.sv
// package: constants and decode tables for the isa bus setup register
package ibs_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [4:0] OFF_SETUP     = 5'h0A;
  localparam logic [1:0] DP_OFF_HI     = 2'h2;
  localparam int         BASE_LSB      = 0;
  localparam int         BASE_MSB      = 2;
  localparam int         IRQ_LSB       = 3;
  localparam int         IRQ_MSB       = 5;
  localparam int         PREFETCH_BIT  = 6;
  localparam logic [7:0] SETUP_RESET   = 8'h00;
  localparam logic [2:0] BASE_SOFTWARE = 3'h1;
  // ****************************************
  // isa address space
  // ****************************************
  localparam int         ADDR_W        = 10;
  localparam int         WIN_LSB       = 5;
  localparam logic [9:0] PORT_SWCFG    = 10'h278;
  localparam logic [1:0] SWCFG_LAST    = 2'h3;
  localparam int         IRQ_LINES     = 16;

  typedef logic [2:0] ibs_sel_t;

  // base address of the 20h byte window
  function automatic logic [9:0] ibs_base(input ibs_sel_t sel);
    case (sel)
      3'h0:    ibs_base = 10'h300;
      3'h2:    ibs_base = 10'h240;
      3'h3:    ibs_base = 10'h280;
      3'h4:    ibs_base = 10'h2C0;
      3'h5:    ibs_base = 10'h320;
      3'h6:    ibs_base = 10'h340;
      3'h7:    ibs_base = 10'h360;
      default: ibs_base = 10'h000;
    endcase
  endfunction

  // interrupt request line number
  function automatic logic [3:0] ibs_irq(input ibs_sel_t sel);
    case (sel)
      3'h0:    ibs_irq = 4'h3;
      3'h1:    ibs_irq = 4'h4;
      3'h2:    ibs_irq = 4'h5;
      3'h3:    ibs_irq = 4'h9;
      3'h4:    ibs_irq = 4'hA;
      3'h5:    ibs_irq = 4'hB;
      3'h6:    ibs_irq = 4'hC;
      default: ibs_irq = 4'hF;
    endcase
  endfunction
endpackage

// File: verilog/ibs_sync.sv
// two flip-flop synchroniser for isa pins
`timescale 1ns/1ps
`default_nettype none
module ibs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1   <= '1;
      sync_out <= '1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

  logic unused_ok;
  assign unused_ok = &reset_val_in;
endmodule
`default_nettype wire

// File: verilog/ibs_setup_reg.sv
// isa bus setup register: decode, protected write, software base, irq routing
// Notes on behaviour
// - reading page-0 offset 0ah returns the setup register contents
// - write at 0ah updates setup only right after a read of 0ah
// - any access in the device window between unlock read and write sends write to byte count low
// - base select bits 0-2 pick one of seven isa base addresses
// - device answers a 20h byte window starting at the selected base
// - base select 001 makes the device answer no isa address
// - four consecutive writes to 278h load the three base select bits
// - software base sequence works once per power-on reset only
// - bits 5-3 pick the interrupt request line
// - bit 6 in io mode starts next data-port fetch before strobe ends
`timescale 1ns/1ps
`default_nettype none
module ibs_setup_reg (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_n_in,
  // isa pins
  input  wire logic [ibs_pkg::ADDR_W-1:0]  isa_addr_in,
  input  wire logic                        isa_aen_in,
  input  wire logic                        isa_iord_n_in,
  input  wire logic                        isa_iowr_n_in,
  input  wire logic [7:0]                  isa_data_in,
  output logic      [7:0]                  isa_data_out,
  output logic                             isa_data_oe_out,
  output logic      [ibs_pkg::IRQ_LINES-1:0] isa_irq_out,
  // core side
  input  wire logic                        page0_in,
  input  wire logic                        io_mode_in,
  input  wire logic                        irq_req_in,
  input  wire logic [7:0]                  core_rdata_in,
  output logic                             core_rd_out,
  output logic                             core_wr_out,
  output logic      [4:0]                  core_offset_out,
  output logic      [7:0]                  core_wdata_out,
  output logic                             byte_count_low_wr_out,
  output logic                             port_fetch_out,
  output logic      [7:0]                  setup_out
);
  import ibs_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [ADDR_W+10:0] pins_s;
  logic [ADDR_W-1:0]  addr_s;
  logic [7:0]         data_s;
  logic               aen_s;
  logic               rd_now;
  logic               wr_now;

  ibs_sync #(.WIDTH(ADDR_W + 11)) u_sync (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .async_in     ({isa_addr_in, isa_data_in, isa_aen_in, isa_iord_n_in, isa_iowr_n_in}),
    .reset_val_in ('1),
    .sync_out     (pins_s)
  );

  assign addr_s = pins_s[ADDR_W+10:11];
  assign data_s = pins_s[10:3];
  assign aen_s  = pins_s[2];
  assign rd_now = ~pins_s[1];
  assign wr_now = ~pins_s[0];

  // ****************************************
  // strobe edges and decode
  // ****************************************
  logic       rd_prev;
  logic       wr_prev;
  logic       setup_unlock;
  logic [7:0] setup;
  logic [1:0] sw_count;
  logic       sw_done;
  logic       dp_access;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_now;
      wr_prev <= wr_now;
    end
  end

  logic       rd_start;
  logic       wr_start;
  logic       any_end;
  ibs_sel_t   base_sel;
  logic [9:0] base_addr;
  logic       hit;
  logic [4:0] offset;
  logic       is_setup;
  logic       is_dp;
  logic       sw_write;

  assign rd_start  = rd_now & ~rd_prev;
  assign wr_start  = wr_now & ~wr_prev;
  assign any_end   = (rd_prev & ~rd_now) | (wr_prev & ~wr_now);
  assign base_sel  = setup[BASE_MSB:BASE_LSB];
  assign base_addr = ibs_base(base_sel);
  assign offset    = addr_s[WIN_LSB-1:0];
  // window of 20h bytes at base; silent in software mode
  assign hit       = ~aen_s & (base_sel != BASE_SOFTWARE) &
                     (addr_s[ADDR_W-1:WIN_LSB] == base_addr[ADDR_W-1:WIN_LSB]);
  assign is_setup  = hit & page0_in & (offset == OFF_SETUP);
  assign is_dp     = hit & (offset[4:3] == DP_OFF_HI);
  assign sw_write  = wr_start & ~aen_s & (addr_s == PORT_SWCFG);

  // ****************************************
  // unlock and setup register
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setup_unlock <= 1'b0;
    end else if (rd_start & is_setup) begin
      setup_unlock <= 1'b1;
    end else if ((rd_start | wr_start) & hit) begin
      setup_unlock <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setup <= SETUP_RESET;
    end else if (wr_start & is_setup & setup_unlock) begin
      setup <= data_s;
    end else if (sw_write & (base_sel == BASE_SOFTWARE) & ~sw_done &
                 (sw_count == SWCFG_LAST)) begin
      setup[BASE_MSB:BASE_LSB] <= data_s[BASE_MSB:BASE_LSB];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_count_low_wr_out <= 1'b0;
    end else begin
      byte_count_low_wr_out <= wr_start & is_setup & ~setup_unlock;
    end
  end

  // ****************************************
  // software base sequence
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_count <= 2'h0;
      sw_done  <= 1'b0;
    end else if (sw_write & (base_sel == BASE_SOFTWARE) & ~sw_done) begin
      sw_count <= sw_count + 2'h1;
      sw_done  <= (sw_count == SWCFG_LAST);
    end else if (wr_start) begin
      sw_count <= 2'h0;
    end
  end

  // ****************************************
  // read data and core access
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      isa_data_out    <= 8'h00;
      isa_data_oe_out <= 1'b0;
    end else begin
      if (rd_start & hit) begin
        isa_data_out    <= is_setup ? setup : core_rdata_in;
        isa_data_oe_out <= 1'b1;
      end else if (!rd_now) begin
        isa_data_oe_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_rd_out     <= 1'b0;
      core_wr_out     <= 1'b0;
      core_offset_out <= 5'h00;
      core_wdata_out  <= 8'h00;
    end else begin
      core_rd_out <= rd_start & hit & ~is_setup;
      core_wr_out <= wr_start & hit & ~is_setup;
      if ((rd_start | wr_start) & hit) begin
        core_offset_out <= offset;
        core_wdata_out  <= data_s;
      end
    end
  end

  // ****************************************
  // data port fetch timing
  // ****************************************
  logic early;
  assign early = setup[PREFETCH_BIT] & io_mode_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dp_access      <= 1'b0;
      port_fetch_out <= 1'b0;
    end else begin
      if (rd_start | wr_start) begin
        dp_access <= is_dp;
      end else if (any_end) begin
        dp_access <= 1'b0;
      end
      // early fetch at strobe start, normal at strobe end
      port_fetch_out <= early ? ((rd_start | wr_start) & is_dp) : (any_end & dp_access);
    end
  end

  // ****************************************
  // irq routing and setup copy
  // ****************************************
  logic [3:0] irq_num;
  assign irq_num = ibs_irq(setup[IRQ_MSB:IRQ_LSB]);

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_LINES; gi++) begin : g_irq
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          isa_irq_out[gi] <= 1'b0;
        end else begin
          isa_irq_out[gi] <= irq_req_in & (irq_num == 4'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setup_out <= SETUP_RESET;
    end else begin
      setup_out <= setup;  // bit 7 stored as written
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_setup_read_data: assert property (rd_start & is_setup |=> isa_data_out == $past(setup)
    && isa_data_oe_out)
    else $error("setup read data wrong");
  a_locked_write_kept: assert property (wr_start & is_setup & ~setup_unlock |=>
    $stable(setup) && byte_count_low_wr_out)
    else $error("locked write changed setup");
  a_unlocked_write: assert property (wr_start & is_setup & setup_unlock |=>
    setup == $past(data_s) && !byte_count_low_wr_out)
    else $error("unlocked write not taken");
  a_unlock_cleared: assert property ((rd_start | wr_start) & hit & ~(rd_start & is_setup) |=>
    !setup_unlock)
    else $error("unlock survived access");
  a_soft_silent: assert property ((rd_start | wr_start) & (base_sel == BASE_SOFTWARE) |=>
    !isa_data_oe_out && !core_rd_out && !core_wr_out && !byte_count_low_wr_out)
    else $error("decode in software mode");
  a_window_size: assert property (hit |-> addr_s - base_addr < 10'h020)
    else $error("decode outside window");
  a_soft_once: assert property (sw_done |=> sw_done && $stable(sw_count))
    else $error("software sequence rerun");
  a_irq_onehot: assert property (irq_req_in |=> isa_irq_out == (16'h0001 << $past(irq_num)))
    else $error("irq routing wrong");
  a_fetch_early: assert property (early & (rd_start | wr_start) & is_dp |=>
    port_fetch_out)
    else $error("early fetch missing");
  a_base_decode: assert property (base_sel == 3'h2 |-> base_addr == 10'h240)
    else $error("base decode wrong");

  c_setup_write: cover property (rd_start & is_setup ##[1:20] wr_start & is_setup & setup_unlock);
  c_redirect: cover property (byte_count_low_wr_out);
  c_soft_load: cover property (!sw_done ##1 sw_done);
  c_early_fetch: cover property (early && port_fetch_out);
endmodule
`default_nettype wire

// File: dv/ibs_host.sv
// isa host model issuing i/o read and write cycles
`timescale 1ns/1ps
`default_nettype none
module ibs_host (
  // clock
  input  wire logic       clk_in,
  // isa pins
  output logic      [9:0] isa_addr_out,
  output logic            isa_iord_n_out,
  output logic            isa_iowr_n_out,
  output logic      [7:0] isa_data_out,
  // device answer
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_oe_in
);
  initial begin
    isa_addr_out = 10'h000;
    isa_iord_n_out = 1'b1;
    isa_iowr_n_out = 1'b1;
    isa_data_out = 8'h00;
  end
  // ****************************************
  // one i/o cycle: setup 3, strobe 6, idle 4
  // ****************************************
  task automatic cyc(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    @(negedge clk_in);
    isa_addr_out = a;
    if (wr) isa_data_out = d;
    repeat (3) @(negedge clk_in);
    if (wr) isa_iowr_n_out = 1'b0;
    else isa_iord_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    q = rd_data_in;
    oe = rd_oe_in;
    isa_iowr_n_out = 1'b1;
    isa_iord_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    // released bus shows no stale value
    isa_data_out = ~isa_data_out;
    isa_addr_out = ~a;
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the isa bus setup register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ibs_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        io_mode = 1'b0;
  logic        irq_req = 1'b0;
  logic        page0 = 1'b1;
  logic [9:0]  addr;
  logic        iord_n, iowr_n, oe, fetch, bcl, crd, cwr;
  logic [4:0]  cofs;
  logic [7:0]  wd, rd, setup, cur, q, cwd;
  logic [15:0] irq;
  logic [9:0]  b;
  int          n_errors = 0, checks = 0, n_bcl = 0, n_fl = 0, n_fa = 0, n_crd = 0, n_cwr = 0;
  logic [9:0]  base_t [8] = '{10'h300, 10'h000, 10'h240, 10'h280, 10'h2C0, 10'h320,
                              10'h340, 10'h360};
  int          irq_t [8] = '{3, 4, 5, 9, 10, 11, 12, 15};
  always #20 clk_in = ~clk_in;
  ibs_host host (.clk_in(clk_in), .isa_addr_out(addr), .isa_iord_n_out(iord_n),
    .isa_iowr_n_out(iowr_n), .isa_data_out(wd), .rd_data_in(rd), .rd_oe_in(oe));
  ibs_setup_reg dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .isa_addr_in(addr),
    .isa_aen_in(1'b0), .isa_iord_n_in(iord_n), .isa_iowr_n_in(iowr_n), .isa_data_in(wd),
    .isa_data_out(rd), .isa_data_oe_out(oe), .isa_irq_out(irq), .page0_in(page0),
    .io_mode_in(io_mode), .irq_req_in(irq_req), .core_rdata_in(8'hC5), .core_rd_out(crd),
    .core_wr_out(cwr), .core_offset_out(cofs), .core_wdata_out(cwd), .byte_count_low_wr_out(bcl),
    .port_fetch_out(fetch), .setup_out(setup));
  // pulse monitors
  always @(posedge clk_in) begin
    if (bcl) n_bcl++;
    if (fetch) n_fa++;
    if (fetch && !iord_n) n_fl++;
    if (crd) n_crd++;
    if (cwr) n_cwr++;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic so;
    host.cyc(1'b1, a, d, q, so);
  endtask
  task automatic rdc(input logic [9:0] a, input logic eoe, input logic [7:0] ed);
    logic [7:0] g;
    logic       go;
    host.cyc(1'b0, a, 8'h00, g, go);
    chk("read enable", {15'h0, eoe}, {15'h0, go});
    if (eoe) chk("read data", {8'h00, ed}, {8'h00, g});
  endtask
  task automatic put(input logic [9:0] bb, input logic [7:0] v);
    rdc(bb + 10'h00A, 1'b1, cur);
    wr(bb + 10'h00A, v);
    cur = v;
  endtask
  task automatic final_report();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    final_report();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cur = 8'h00;
    b = 10'h300;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("setup reset", 16'h0000, {8'h00, setup});
    put(b, 8'h08);
    chk("setup out", 16'h0008, {8'h00, setup});
    rdc(10'h30A, 1'b1, 8'h08);
    page0 = 1'b0;
    rdc(10'h30A, 1'b1, 8'hC5);
    page0 = 1'b1;
    rdc(10'h301, 1'b1, 8'hC5);
    chk("core reads", 16'h0002, n_crd[15:0]);
    chk("core offset", 16'h0001, {11'h000, cofs});
    wr(10'h30A, 8'h3F);
    chk("redirect", 16'h0001, n_bcl[15:0]);
    chk("redirect data", 16'h003F, {8'h00, cwd});
    chk("redirect offset", 16'h000A, {11'h000, cofs});
    chk("setup kept", 16'h0008, {8'h00, setup});
    rdc(10'h30A, 1'b1, 8'h08);
    for (int s = 0; s < 8; s++) begin
      if (s == 1) continue;
      put(b, {cur[7:3], 3'(s)});
      b = base_t[s];
      rdc(b + 10'h01F, 1'b1, 8'hC5);
      rdc(b + 10'h020, 1'b0, 8'h00);
      rdc(b - 10'h001, 1'b0, 8'h00);
    end
    irq_req = 1'b1;
    for (int s = 0; s < 8; s++) begin
      put(b, {2'b00, 3'(s), cur[2:0]});
      chk("irq line", 16'(1 << irq_t[s]), irq);
    end
    irq_req = 1'b0;
    io_mode = 1'b1;
    rdc(b + 10'h010, 1'b1, 8'hC5);
    chk("slow fetch", 16'h0000, n_fl[15:0]);
    chk("irq idle", 16'h0000, irq);
    put(b, {2'b01, cur[5:0]});
    rdc(b + 10'h010, 1'b1, 8'hC5);
    chk("fast fetch", 16'h0001, n_fl[15:0]);
    chk("fetch count", 16'h0002, n_fa[15:0]);
    wr(b + 10'h010, 8'h5A);
    chk("core writes", 16'h0001, n_cwr[15:0]);
    chk("core wdata", 16'h005A, {8'h00, cwd});
    chk("write fetch", 16'h0003, n_fa[15:0]);
    put(b, {cur[7:3], 3'h1});
    rdc(b + 10'h00A, 1'b0, 8'h00);
    for (int i = 0; i < 4; i++) wr(10'h278, 8'h02 + 8'(i == 3));
    cur = {cur[7:3], 3'h3};
    rdc(10'h28A, 1'b1, cur);
    put(10'h280, {cur[7:3], 3'h1});
    for (int i = 0; i < 4; i++) wr(10'h278, 8'h03);
    rdc(10'h28A, 1'b0, 8'h00);
    rdc(10'h30A, 1'b0, 8'h00);
    // second power-on reset re-arms the software sequence
    reset_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("setup rereset", 16'h0000, {8'h00, setup});
    cur = 8'h00;
    put(10'h300, 8'h01);
    for (int i = 0; i < 4; i++) wr(10'h278, 8'h06);
    rdc(10'h34A, 1'b1, 8'h06);
    final_report();
  end
endmodule
`default_nettype wire
